// file: logic/smta_access.v
// register bank and sequencer for static, multicast and dynamic table access
`timescale 1ns/1ps
module smta_access
(
   // clock and reset
   input  wire        clock_i,
   input  wire        rst_i,
   // register port
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [15:0] reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   output reg  [31:0] reg_rdata_o,
   output reg         reg_ack_o,
   // status
   output reg         busy_o
);
`include "smta_regs.vh"
   // access sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_LOAD = 2'h2;
   localparam ST_DONE = 2'h3;
   // register slots decoded from the byte address
   localparam SL_NONE = 3'h0;
   localparam SL_DYN  = 3'h1;
   localparam SL_CTRL = 3'h2;
   localparam SL_ENT1 = 3'h3;
   localparam SL_ENT2 = 3'h4;
   localparam SL_ENT3 = 3'h5;
   localparam SL_ENT4 = 3'h6;

   reg [31:0]  ctrl_q;
   reg [31:0]  dyn_q;
   reg [31:0]  ent_q [0:3];
   reg [1:0]   state_q;
   reg [1:0]   state_d;
   reg         dyn_op_q;
   reg         mem_we;
   reg [1:0]   mem_tsel;
   reg [5:0]   mem_row;
   wire [127:0] mem_rdata;
   wire [127:0] ent_all;
   wire [127:0] ent_new;
   wire [2:0]  slot;
   wire        go_any;
   wire        dyn_wr_act;
   wire        dyn_rd_act;
   wire        rd_dir;
   integer     k;

   // row index: six bits for multicast, four for static and dynamic
   function [5:0] row_sel;
      input [1:0] t;
      input [5:0] idx;
      begin
         if (t == 2'h1)
            row_sel = idx;
         else
            row_sel = {2'h0, idx[3:0]};
      end
   endfunction

   // byte address to register slot; unmapped offsets fall to SL_NONE
   function [2:0] reg_slot;
      input [15:0] a;
      begin
         case (a)
            `SMTA_OFS_DYN_CTRL: reg_slot = SL_DYN;
            `SMTA_OFS_CTRL:     reg_slot = SL_CTRL;
            `SMTA_OFS_ENTRY1:   reg_slot = SL_ENT1;
            `SMTA_OFS_ENTRY2:   reg_slot = SL_ENT2;
            `SMTA_OFS_ENTRY3:   reg_slot = SL_ENT3;
            `SMTA_OFS_ENTRY4:   reg_slot = SL_ENT4;
            default:            reg_slot = SL_NONE;
         endcase
      end
   endfunction

   // entry words after a read: only the words that the table owns take the row
   function [127:0] load_merge;
      input         dyn;
      input         mcast;
      input [127:0] old;
      input [127:0] row;
      begin
         if (dyn)
            load_merge = {row[127:96], old[95:32], row[31:0]};
         else if (mcast)
            load_merge = {old[127:64], row[63:32], old[31:0]};
         else
            load_merge = row;
      end
   endfunction

   assign slot    = reg_slot(reg_addr_i);
   assign ent_all = {ent_q[3], ent_q[2], ent_q[1], ent_q[0]};
   assign ent_new = load_merge(dyn_op_q, ctrl_q[`SMTA_BIT_TSEL], ent_all, mem_rdata);
   assign go_any  = ctrl_q[`SMTA_BIT_GO] | dyn_q[`SMTA_BIT_GO];

   // dynamic action codes other than write and read just complete
   assign dyn_wr_act = (dyn_q[`SMTA_DYN_ACT_HI:`SMTA_DYN_ACT_LO] == `SMTA_ACT_WR);
   assign dyn_rd_act = (dyn_q[`SMTA_DYN_ACT_HI:`SMTA_DYN_ACT_LO] == `SMTA_ACT_RD);
   assign rd_dir     = dyn_op_q ? dyn_rd_act : ctrl_q[`SMTA_BIT_RD];

   always @*
   begin
      if (dyn_op_q)
         mem_tsel = 2'h2;
      else
         mem_tsel = {1'b0, ctrl_q[`SMTA_BIT_TSEL]};
      mem_row = row_sel(mem_tsel, dyn_op_q ? {2'h0, dyn_q[`SMTA_DYN_IDX_HI:`SMTA_DYN_IDX_LO]}
                                           : ctrl_q[`SMTA_IDX_HI:`SMTA_IDX_LO]);
      mem_we  = (state_q == ST_RUN) && !rd_dir && (!dyn_op_q || dyn_wr_act);
   end

   // next state of the access sequencer
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (go_any)
               state_d = ST_RUN;
         end
         ST_RUN:
            state_d = rd_dir ? ST_LOAD : ST_DONE;
         ST_LOAD:
            state_d = ST_DONE;
         ST_DONE:
            state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // one row store per table; its read port is registered
   smta_table_mem u_mem
   (
      .clock_i (clock_i),
      .we_i    (mem_we),
      .tsel_i  (mem_tsel),
      .row_i   (mem_row),
      .wdata_i (ent_all),
      .rdata_o (mem_rdata)
   );

   // register bank, read-back and the access sequencer
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ctrl_q      <= `SMTA_CTRL_RST;
         dyn_q       <= `SMTA_CTRL_RST;
         for (k = 0; k < 4; k = k + 1)
            ent_q[k] <= `SMTA_ENTRY_RST;
         state_q     <= ST_IDLE;
         dyn_op_q    <= 1'b0;
         reg_rdata_o <= 32'h00000000;
         reg_ack_o   <= 1'b0;
         busy_o      <= 1'b0;
      end
      else
      begin
         reg_ack_o <= reg_wr_i | reg_rd_i;
         state_q   <= state_d;
         busy_o    <= (state_d != ST_IDLE);

         // row and reserved bits of the dynamic control read back as zero
         if (reg_rd_i)
         begin
            case (slot)
               SL_CTRL: reg_rdata_o <= ctrl_q;
               SL_DYN:  reg_rdata_o <= dyn_q & `SMTA_DYN_RMASK;
               SL_ENT1: reg_rdata_o <= ent_q[0];
               SL_ENT2: reg_rdata_o <= ent_q[1];
               SL_ENT3: reg_rdata_o <= ent_q[2];
               SL_ENT4: reg_rdata_o <= ent_q[3];
               default: reg_rdata_o <= 32'h00000000;
            endcase
         end

         // software writes ignored while busy
         if (reg_wr_i && state_q == ST_IDLE)
         begin
            case (slot)
               SL_CTRL: ctrl_q   <= reg_wdata_i & `SMTA_CTRL_WMASK;
               SL_DYN:  dyn_q    <= reg_wdata_i & `SMTA_DYN_WMASK;
               SL_ENT1: ent_q[0] <= reg_wdata_i;
               SL_ENT2: ent_q[1] <= reg_wdata_i;
               SL_ENT3: ent_q[2] <= reg_wdata_i;
               SL_ENT4: ent_q[3] <= reg_wdata_i;
               default: ;
            endcase
         end

         case (state_q)
            ST_IDLE:
            begin
               // static or multicast access wins when both go bits are set
               if (ctrl_q[`SMTA_BIT_GO])
                  dyn_op_q <= 1'b0;
               else if (dyn_q[`SMTA_BIT_GO])
                  dyn_op_q <= 1'b1;
            end
            ST_RUN:
               ; // the row store writes or fetches in this cycle
            ST_LOAD:
            begin
               for (k = 0; k < 4; k = k + 1)
                  ent_q[k] <= ent_new[32*k +: 32];
            end
            ST_DONE:
            begin
               if (dyn_op_q)
                  dyn_q[`SMTA_BIT_GO] <= 1'b0;
               else
                  ctrl_q[`SMTA_BIT_GO] <= 1'b0;
            end
            default:
               ;
         endcase
      end
   end
endmodule // smta_access

// file: logic/smta_regs.vh
// register offsets, fields and reset values of the fixed table access block
`ifndef SMTA_REGS_VH
`define SMTA_REGS_VH
`define SMTA_OFS_DYN_CTRL   16'h0418
`define SMTA_OFS_CTRL       16'h041C
`define SMTA_OFS_ENTRY1     16'h0420
`define SMTA_OFS_ENTRY2     16'h0424
`define SMTA_OFS_ENTRY3     16'h0428
`define SMTA_OFS_ENTRY4     16'h042C
`define SMTA_BIT_GO         7
`define SMTA_BIT_TSEL       1
`define SMTA_BIT_RD         0
`define SMTA_IDX_HI         21
`define SMTA_IDX_LO         16
`define SMTA_CTRL_WMASK     32'h003F00FF
`define SMTA_DYN_WMASK      32'h000F009F
`define SMTA_DYN_RMASK      32'h0000009F
`define SMTA_DYN_ACT_HI     1
`define SMTA_DYN_ACT_LO     0
`define SMTA_ACT_WR         2'h1
`define SMTA_ACT_RD         2'h2
`define SMTA_DYN_IDX_HI     19
`define SMTA_DYN_IDX_LO     16
`define SMTA_CTRL_RST       32'h00000000
`define SMTA_ENTRY_RST      32'h00000000
`define SMTA_STATIC_ROWS    16
`define SMTA_MCAST_ROWS     64
`define SMTA_DYN_ROWS       16
`endif

// file: logic/smta_table_mem.v
// row storage for static, multicast and dynamic lookup tables
`timescale 1ns/1ps
module smta_table_mem
(
   // clock
   input  wire         clock_i,
   // access
   input  wire         we_i,
   input  wire [1:0]   tsel_i,
   input  wire [5:0]   row_i,
   input  wire [127:0] wdata_i,
   output reg  [127:0] rdata_o
);
`include "smta_regs.vh"
   reg [127:0] stat_mem [0:`SMTA_STATIC_ROWS-1];
   reg [31:0]  mc_mem   [0:`SMTA_MCAST_ROWS-1];
   reg [63:0]  dyn_mem  [0:`SMTA_DYN_ROWS-1];

   always @(posedge clock_i)
   begin
      if (we_i)
      begin
         case (tsel_i)
            2'h0:    stat_mem[row_i[3:0]] <= wdata_i;
            2'h1:    mc_mem[row_i] <= wdata_i[63:32];
            default: dyn_mem[row_i[3:0]] <= {wdata_i[127:96], wdata_i[31:0]};
         endcase
      end
      case (tsel_i)
         2'h0:    rdata_o <= stat_mem[row_i[3:0]];
         2'h1:    rdata_o <= {64'h0000000000000000, mc_mem[row_i], 32'h00000000};
         default: rdata_o <= {dyn_mem[row_i[3:0]][63:32], 64'h0000000000000000,
                              dyn_mem[row_i[3:0]][31:0]};
      endcase
   end
endmodule // smta_table_mem

// file: tb/smta_asserts.sv
// port assertions of the table access block
`timescale 1ns/1ps
module smta_asserts
(
   input wire        clock_i,
   input wire        rst_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [15:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire [31:0] reg_rdata_o,
   input wire        reg_ack_o,
   input wire        busy_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire rq = reg_wr_i | reg_rd_i;
   wire um = !(reg_addr_i inside {16'h0418, 16'h041C, 16'h0420, 16'h0424, 16'h0428, 16'h042C});
   property p_ack; rq |=> reg_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_noack; !rq |=> !reg_ack_o; endproperty
   a_noack: assert property (p_noack) else $error("ack without request");
   property p_go; reg_wr_i && reg_addr_i == 16'h041C && reg_wdata_i[7] && !busy_o |-> ##[1:2] busy_o; endproperty
   a_go: assert property (p_go) else $error("access did not start");
   property p_end; $rose(busy_o) |-> ##[2:4] !busy_o; endproperty
   a_end: assert property (p_end) else $error("access did not finish");
   property p_rsv; reg_rd_i && reg_addr_i == 16'h041C |=> (reg_rdata_o & 32'hFFC0FF00) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("control reserved bits set");
   property p_dyn; reg_rd_i && reg_addr_i == 16'h0418 |=> (reg_rdata_o & 32'hFFFFFF60) == 32'h0; endproperty
   a_dyn: assert property (p_dyn) else $error("dynamic control reserved bits set");
   property p_um; reg_rd_i && um |=> reg_rdata_o == 32'h0; endproperty
   a_um: assert property (p_um) else $error("unmapped read not zero");
   property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule // smta_asserts
bind smta_access smta_asserts u_chk (.clock_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
   .reg_rdata_o, .reg_ack_o, .busy_o);

// file: tb/smta_host.sv
// host model issuing register writes and reads
`timescale 1ns/1ps
module smta_host
(
   // clock and answer
   input  wire        clock_i,
   input  wire [31:0] rdata_i,
   input  wire        ack_i,
   // request
   output reg         wr_o,
   output reg         rd_o,
   output reg  [15:0] addr_o,
   output reg  [31:0] wdata_o
);
   reg got_ack;
   initial {wr_o, rd_o, addr_o, wdata_o} = 50'h0;
   task xfer(input w, input [15:0] a, input [31:0] d, output [31:0] q);
      integer n;
      begin
         @(posedge clock_i);
         {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
         @(posedge clock_i);
         {wr_o, rd_o} <= 2'h0;
         n = 0;
         do @(posedge clock_i); while (ack_i !== 1'b1 && ++n < 4);
         got_ack = (ack_i === 1'b1);
         q = rdata_i;
      end
   endtask
endmodule // smta_host

// file: tb/test_smta_access.sv
// testbench of the table access block
`timescale 1ns/1ps
module test_smta_access;
   reg          clock_i = 1'b0;
   reg          rst_i = 1'b1;
   wire         wr, rd, ack, busy;
   wire [15:0]  addr;
   wire [31:0]  wd, rdat;
   reg  [31:0]  q;
   integer      n_errors = 0, total_checks = 0, cyc = 0, i;
   always #12.5 clock_i = ~clock_i;
   smta_access DUT (.clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_ack_o(ack), .busy_o(busy));
   smta_host host (.clock_i(clock_i), .rdata_i(rdat), .ack_i(ack), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wd));
   task chk(input [31:0] s, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (s !== e)
         begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t seen=%h expected=%h", $time, s, e);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task w(input [15:0] a, input [31:0] d);
      begin
         host.xfer(1'b1, a, d, q);
         chk({31'h0, host.got_ack}, 32'h1);
      end
   endtask
   task r(input [15:0] a, input [31:0] e);
      begin
         host.xfer(1'b0, a, 32'h0, q);
         chk({31'h0, host.got_ack}, 32'h1);
         chk(q, e);
      end
   endtask
   // launch an access and poll until the go bit drops
   task run(input [15:0] a, input [31:0] c);
      begin
         w(a, c);
         @(posedge clock_i);
         chk(busy, 32'h1);
         i = 0;
         do host.xfer(1'b0, a, 32'h0, q); while (q[7] === 1'b1 && ++i < 10);
         chk(q & 32'h80, 32'h0);
         chk(busy, 32'h0);
      end
   endtask
   task t_static;
      begin
         for (i = 0; i < 4; i++) w(16'h0420 + 4 * i, 32'h5A000000 + i);
         run(16'h041C, 32'h00050080);
         for (i = 0; i < 4; i++) w(16'h0420 + 4 * i, 32'h0);
         run(16'h041C, 32'h00350081);
         r(16'h041C, 32'h00350001);
         for (int k = 0; k < 4; k++) r(16'h0420 + 4 * k, 32'h5A000000 + k);
      end
   endtask
   task t_mcast;
      begin
         w(16'h0424, 32'hC0DE0025);
         run(16'h041C, 32'h00250082);
         w(16'h0424, 32'h00001111);
         run(16'h041C, 32'h00050082);
         w(16'h0420, 32'h00000007);
         run(16'h041C, 32'h00250083);
         r(16'h0424, 32'hC0DE0025);
         r(16'h0420, 32'h00000007);
         run(16'h041C, 32'h00050081);
         r(16'h0424, 32'h5A000001);
      end
   endtask
   task t_dyn;
      begin
         w(16'h0420, 32'h000000D1);
         w(16'h042C, 32'h000000D4);
         run(16'h0418, 32'h00030081);
         w(16'h0420, 32'h000000E1);
         w(16'h042C, 32'h000000E4);
         run(16'h0418, 32'h00060081);
         w(16'h0420, 32'h0);
         w(16'h042C, 32'h0);
         run(16'h0418, 32'h00030082);
         r(16'h0418, 32'h00000002);
         r(16'h0420, 32'h000000D1);
         r(16'h042C, 32'h000000D4);
         r(16'h0428, 32'h5A000002);
      end
   endtask
   // reset in the middle of a multicast read
   task t_reset;
      begin
         w(16'h041C, 32'h00250083);
         rst_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         rst_i <= 1'b0;
         chk(busy, 32'h0);
         r(16'h041C, 32'h0);
         r(16'h0424, 32'h0);
      end
   endtask
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors = n_errors + 1;
         wrap_up;
      end
   end
   initial
   begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 6; k++) r(16'h0418 + 4 * k, 32'h0);
      r(16'h0430, 32'h0);
      t_static;
      t_mcast;
      t_dyn;
      t_reset;
      wrap_up;
   end
endmodule // test_smta_access
